// ---- core/comparator_control_registers.sv ----
// AXI4-Lite register block of the analog comparator with event status and interrupt
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "comp_regs_consts.svh"

module comparator_control_registers
	import comp_regs_pkg::*;
(
	input wire logic clk, // 200 MHz system clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic [11:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [11:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic sampleTask, // Sample task pulse, same clock
	input wire logic compOut, // Analog comparator decision, asynchronous
	input wire logic compReady, // Analog core ready level, asynchronous
	output comp_cfg_s cfg, // Configuration to the analog core
	output logic irq // Level interrupt
);

	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [11:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic [31:0] wMask;
	logic [31:0] wEff;
	logic wrMapped;
	comp_cfg_s cfg_r;
	comp_cfg_s cfg_nxt;
	logic [3:0] irqEn_r;
	logic [3:0] irqEn_nxt;
	evt_t status_r;
	evt_t status_nxt;
	evt_t evt;
	logic result_r;
	logic irq_r;
	logic compMeta_r;
	logic compLevel_r;
	logic compPrev_r;
	logic readyMeta_r;
	logic readyLevel_r;
	logic readyPrev_r;
	logic [31:0] rdMux;
	logic rdMapped;

	function automatic logic [31:0] mergeField(input logic [31:0] oldVal, input logic [31:0] newVal,
		input logic [31:0] m);
		mergeField = (oldVal & ~m) | (newVal & m);
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == `OFF_IRQ_DIRECT) || (a == `OFF_IRQ_SET) || (a == `OFF_IRQ_CLEAR) ||
			(a == `OFF_RESULT) || (a == `OFF_ENABLE) || (a == `OFF_PIN_CHOICE) ||
			(a == `OFF_REF_CHOICE) || (a == `OFF_EXTREF_CHOICE) || (a == `OFF_EITHER_DIRECTION_EVENT_LEVELS) ||
			(a == `OFF_MODE) || (a == `OFF_BAND_ENABLE) || (a == `OFF_EVENT_STATUS);
	endfunction

	// Write channel: address and data taken in either order, response after both
	assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
	assign wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
	assign wEff = wData_r & wMask;
	assign wrMapped = isMapped(awAddr_r);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awready_r <= 1'b0;
			awHeld_r <= 1'b0;
			awAddr_r <= 12'h000;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			awHeld_r <= 1'b1;
			awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
		end else begin
			if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (!awHeld_r && !bvalid_r) begin
				awready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wready_r <= 1'b0;
			wHeld_r <= 1'b0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
		end else begin
			if (doWrite) begin
				wHeld_r <= 1'b0;
			end
			if (!wHeld_r && !bvalid_r) begin
				wready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (doWrite) begin
			bvalid_r <= 1'b1;
			bresp_r <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Configuration fields, narrow fields sit in the low bits except the topology bit at bit 8 of the mode register
	always_comb begin
		cfg_nxt = cfg_r;
		if (doWrite) begin
			unique case (awAddr_r)
				`OFF_ENABLE: cfg_nxt.enable = 2'(mergeField(32'(cfg_r.enable), wData_r, wMask));
				`OFF_PIN_CHOICE: cfg_nxt.pinChoice = 3'(mergeField(32'(cfg_r.pinChoice), wData_r, wMask));
				`OFF_REF_CHOICE: cfg_nxt.refChoice = 3'(mergeField(32'(cfg_r.refChoice), wData_r, wMask)); // [R03]
				`OFF_EXTREF_CHOICE: cfg_nxt.extRefChoice =
					3'(mergeField(32'(cfg_r.extRefChoice), wData_r, wMask)); // [R04]
				`OFF_EITHER_DIRECTION_EVENT_LEVELS: cfg_nxt.crossingLevels = mergeField(cfg_r.crossingLevels, wData_r, wMask);
				`OFF_MODE: begin
					if (wStrb_r[0]) begin
						cfg_nxt.latencyPowerLevel = wData_r[`MODE_SPEED_LSB +: 2]; // [R05]
					end
					if (wStrb_r[1]) begin
						cfg_nxt.differential = wData_r[`MODE_DIFF_BIT]; // [R06]
					end
				end
				`OFF_BAND_ENABLE: begin
					if (wStrb_r[0]) begin
						cfg_nxt.hysteresis = wData_r[0]; // [R07]
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r.enable <= 2'h0;
			cfg_r.pinChoice <= 3'h0;
			cfg_r.refChoice <= `RST_REF_CHOICE; // [R03]
			cfg_r.extRefChoice <= `RST_EXTREF_CHOICE; // [R04]
			cfg_r.crossingLevels <= 32'h00000000;
			cfg_r.latencyPowerLevel <= SPEED_LOW;
			cfg_r.differential <= 1'b0; // [R06]
			cfg_r.hysteresis <= 1'b0; // [R07]
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// One enable state behind the direct, set and clear views
	always_comb begin
		irqEn_nxt = irqEn_r;
		if (doWrite) begin
			if (awAddr_r == `OFF_IRQ_DIRECT && wStrb_r[0]) begin
				irqEn_nxt = wData_r[3:0]; // [R09]
			end
			if (awAddr_r == `OFF_IRQ_SET) begin
				irqEn_nxt = irqEn_r | wEff[3:0]; // [R08]
			end
			if (awAddr_r == `OFF_IRQ_CLEAR) begin
				irqEn_nxt = irqEn_r & ~wEff[3:0]; // [R01]
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqEn_r <= `RST_IRQ_EN; // [R09]
		end else begin
			irqEn_r <= irqEn_nxt;
		end
	end

	// Two-stage synchronisers for the analog levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			compMeta_r <= 1'b0;
			compLevel_r <= 1'b0;
			compPrev_r <= 1'b0;
			readyMeta_r <= 1'b0;
			readyLevel_r <= 1'b0;
			readyPrev_r <= 1'b0;
		end else begin
			compMeta_r <= compOut;
			compLevel_r <= compMeta_r;
			compPrev_r <= compLevel_r;
			readyMeta_r <= compReady;
			readyLevel_r <= readyMeta_r;
			readyPrev_r <= readyLevel_r;
		end
	end

	always_comb begin
		evt = '0;
		evt[`EVT_READY] = readyLevel_r && !readyPrev_r;
		evt[`EVT_DOWN] = compPrev_r && !compLevel_r;
		evt[`EVT_UP] = !compPrev_r && compLevel_r;
		evt[`EVT_EITHER_DIRECTION_EVENT] = compPrev_r != compLevel_r;
	end

	// Result only moves on the sample task; bus writes never touch it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_r <= 1'b0;
		end else if (sampleTask) begin
			result_r <= compLevel_r; // [R02] [R10]
		end
	end

	// Sticky status, an event in the clearing cycle survives
	always_comb begin
		status_nxt = status_r;
		if (doWrite && awAddr_r == `OFF_EVENT_STATUS) begin
			status_nxt = status_r & ~wEff[3:0];
		end
		status_nxt = status_nxt | evt;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= 4'h0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_r & irqEn_r);
		end
	end

	// Read channel
	always_comb begin
		rdMux = 32'h00000000;
		rdMapped = isMapped({s_axi_araddr[11:2], 2'b00});
		unique case ({s_axi_araddr[11:2], 2'b00})
			`OFF_IRQ_DIRECT, `OFF_IRQ_SET, `OFF_IRQ_CLEAR: rdMux[3:0] = irqEn_r; // [R01] [R08]
			`OFF_RESULT: rdMux[0] = result_r; // [R02]
			`OFF_ENABLE: rdMux[1:0] = cfg_r.enable;
			`OFF_PIN_CHOICE: rdMux[2:0] = cfg_r.pinChoice;
			`OFF_REF_CHOICE: rdMux[2:0] = cfg_r.refChoice;
			`OFF_EXTREF_CHOICE: rdMux[2:0] = cfg_r.extRefChoice;
			`OFF_EITHER_DIRECTION_EVENT_LEVELS: rdMux = cfg_r.crossingLevels;
			`OFF_MODE: begin
				rdMux[`MODE_SPEED_LSB +: 2] = cfg_r.latencyPowerLevel;
				rdMux[`MODE_DIFF_BIT] = cfg_r.differential;
			end
			`OFF_BAND_ENABLE: rdMux[0] = cfg_r.hysteresis;
			`OFF_EVENT_STATUS: rdMux[3:0] = status_r;
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rdMux;
			rresp_r <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign cfg = cfg_r;
	assign irq = irq_r;

	property p_clearDisables;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_IRQ_CLEAR |=> (irqEn_r & $past(wEff[3:0])) == 4'h0;
	endproperty
	a_clearDisables: assert property (p_clearDisables) else $error("clear write left an enable on"); // [R01]

	property p_resultSample;
		@(posedge clk) disable iff (!resetn)
		sampleTask |=> result_r == $past(compLevel_r);
	endproperty
	a_resultSample: assert property (p_resultSample) else $error("result not latched at sample"); // [R02]

	property p_refChoiceWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_REF_CHOICE && wStrb_r[0] |=> cfg_r.refChoice == $past(wData_r[2:0]);
	endproperty
	a_refChoiceWrite: assert property (p_refChoiceWrite) else $error("reference choice not written"); // [R03]

	property p_extRefWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_EXTREF_CHOICE && wStrb_r[0] |=> cfg_r.extRefChoice == $past(wData_r[2:0]);
	endproperty
	a_extRefWrite: assert property (p_extRefWrite) else $error("external reference not written"); // [R04]

	property p_speedWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_MODE && wStrb_r[0] |=> cfg_r.latencyPowerLevel == $past(wData_r[1:0]);
	endproperty
	a_speedWrite: assert property (p_speedWrite) else $error("speed field not written"); // [R05]

	property p_diffWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_MODE && wStrb_r[1] |=> cfg_r.differential == $past(wData_r[8]);
	endproperty
	a_diffWrite: assert property (p_diffWrite) else $error("topology bit not written"); // [R06]

	property p_bandWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_BAND_ENABLE && wStrb_r[0] |=> cfg_r.hysteresis == $past(wData_r[0]);
	endproperty
	a_bandWrite: assert property (p_bandWrite) else $error("hysteresis bit not written"); // [R07]

	property p_setEnables;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_IRQ_SET |=> (irqEn_r & $past(wEff[3:0])) == $past(wEff[3:0]);
	endproperty
	a_setEnables: assert property (p_setEnables) else $error("set write did not enable"); // [R08]

	property p_directWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_IRQ_DIRECT && wStrb_r[0] |=> irqEn_r == $past(wData_r[3:0]);
	endproperty
	a_directWrite: assert property (p_directWrite) else $error("direct enable not written"); // [R09]

	property p_resultIgnoresWrite;
		@(posedge clk) disable iff (!resetn)
		doWrite && awAddr_r == `OFF_RESULT && !sampleTask |=> $stable(result_r);
	endproperty
	a_resultIgnoresWrite: assert property (p_resultIgnoresWrite) else $error("result changed by write"); // [R10]

	property p_irqLevel;
		@(posedge clk) disable iff (!resetn)
		##1 irq_r == $past(|(status_r & irqEn_r));
	endproperty
	a_irqLevel: assert property (p_irqLevel) else $error("interrupt level mismatch");

endmodule
`default_nettype wire

// ---- shared/comp_regs_consts.svh ----
// Offsets, field positions, reset values and bus codes of the comparator register block
// Summary of operation
// [R01] Clear register ones disable event interrupts
// [R02] Result latches comparison at sample task
// [R03] Reference select resets to four
// [R04] External reference picks input channel zero-seven
// [R05] Speed field: low, normal, high-speed
// [R06] Topology bit: single-ended or differential, reset zero
// [R07] Hysteresis bit off at reset, one enables
// [R08] Set register ones enable; shared enable state
// [R09] Direct enable register writable, resets cleared
// [R10] Writes to result register are ignored
`ifndef COMP_REGS_CONSTS_SVH
`define COMP_REGS_CONSTS_SVH

`define OFF_IRQ_DIRECT 12'h300
`define OFF_IRQ_SET 12'h304
`define OFF_IRQ_CLEAR 12'h308
`define OFF_RESULT 12'h400
`define OFF_ENABLE 12'h500
`define OFF_PIN_CHOICE 12'h504
`define OFF_REF_CHOICE 12'h508
`define OFF_EXTREF_CHOICE 12'h50c
`define OFF_EITHER_DIRECTION_EVENT_LEVELS 12'h530
`define OFF_MODE 12'h534
`define OFF_BAND_ENABLE 12'h538
`define OFF_EVENT_STATUS 12'h600

`define EVT_READY 0
`define EVT_DOWN 1
`define EVT_UP 2
`define EVT_EITHER_DIRECTION_EVENT 3

`define MODE_SPEED_LSB 0
`define MODE_DIFF_BIT 8

`define RST_REF_CHOICE 3'h4
`define RST_EXTREF_CHOICE 3'h0
`define RST_IRQ_EN 4'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- shared/comp_regs_pkg.sv ----
// Types shared by the comparator register block
package comp_regs_pkg;

	typedef enum logic [1:0] {
		SPEED_LOW = 2'b00,
		SPEED_NORMAL = 2'b01,
		SPEED_HIGH = 2'b10
	} latency_power_level_e;

	typedef enum logic [2:0] {
		REF_INT_1V2 = 3'b000,
		REF_INT_1V8 = 3'b001,
		REF_INT_2V4 = 3'b010,
		REF_SUPPLY = 3'b100,
		REF_EXT_PIN = 3'b101
	} reference_source_choice_e;

	typedef struct packed {
		logic [1:0] enable;
		logic [2:0] pinChoice;
		logic [2:0] refChoice;
		logic [2:0] extRefChoice;
		logic [31:0] crossingLevels;
		logic [1:0] latencyPowerLevel;
		logic differential;
		logic hysteresis;
	} comp_cfg_s;

	typedef logic [3:0] evt_t;

endpackage

// ---- testbench/testbench.sv ----
// Self-checking bench of the comparator register block over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "comp_regs_consts.svh"

module testbench
	import comp_regs_pkg::*;
;
	logic clk, resetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic sampleTask, compOut, compReady, irq;
	comp_cfg_s cfg;
	int n_mismatch = 0;
	int checks_done = 0;
	int i;

	comparator_control_registers comparator_control_registers_inst (
		.clk(clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sampleTask(sampleTask),
		.compOut(compOut), .compReady(compReady), .cfg(cfg), .irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("Counts: %0d comparisons, %0d mismatches", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic timed_out();
		n_mismatch++;
		$display("CHECK FAILED at %0t: bus answer never came", $time);
		wrap_up();
	endtask

	// Write with address and data offered together, response checked
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		logic b;
		b = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 200 && !b; n++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				b = 1'b1;
				s_axi_bready <= 1'b0;
				chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
			end
		end
		if (!b) timed_out();
		@(posedge clk);
	endtask

	// Read one word and compare data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic b;
		b = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200 && !b; n++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				b = 1'b1;
				s_axi_rready <= 1'b0;
				chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
				chk(s_axi_rdata, ed, "read data");
			end
		end
		if (!b) timed_out();
		@(posedge clk);
	endtask

	task automatic wait_irq(input logic exp);
		int n;
		for (n = 0; n < 20 && irq !== exp; n++) @(posedge clk);
		chk({31'h0, irq}, {31'h0, exp}, "interrupt level");
	endtask

	initial begin
		resetn = 1'b0;
		s_axi_awaddr = 12'h000; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 12'h000; s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0; sampleTask = 1'b0; compOut = 1'b0; compReady = 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);

		rd(`OFF_IRQ_DIRECT, 32'h0, 2'h0);
		rd(`OFF_REF_CHOICE, 32'h4, 2'h0);
		chk({29'h0, cfg.refChoice}, 32'h4, "reference output at reset");
		rd(`OFF_EXTREF_CHOICE, 32'h0, 2'h0);
		rd(`OFF_MODE, 32'h0, 2'h0);
		rd(`OFF_BAND_ENABLE, 32'h0, 2'h0);
		rd(`OFF_ENABLE, 32'h0, 2'h0);
		rd(`OFF_PIN_CHOICE, 32'h0, 2'h0);
		rd(`OFF_EITHER_DIRECTION_EVENT_LEVELS, 32'h0, 2'h0);
		rd(`OFF_RESULT, 32'h0, 2'h0);
		$display("Test reset values done");

		wr(`OFF_IRQ_SET, 32'hf, 4'hf, 2'h0);
		rd(`OFF_IRQ_DIRECT, 32'hf, 2'h0);
		rd(`OFF_IRQ_SET, 32'hf, 2'h0);
		wr(`OFF_IRQ_CLEAR, 32'h5, 4'hf, 2'h0);
		rd(`OFF_IRQ_CLEAR, 32'ha, 2'h0);
		wr(`OFF_IRQ_CLEAR, 32'h0, 4'hf, 2'h0);
		rd(`OFF_IRQ_SET, 32'ha, 2'h0);
		wr(`OFF_IRQ_DIRECT, 32'h3, 4'hf, 2'h0);
		rd(`OFF_IRQ_CLEAR, 32'h3, 2'h0);
		wr(`OFF_IRQ_DIRECT, 32'h0, 4'hf, 2'h0);
		rd(`OFF_IRQ_DIRECT, 32'h0, 2'h0);
		$display("Test interrupt enables done");

		for (i = 0; i < 6; i++) begin
			if (i != 3) begin
				wr(`OFF_REF_CHOICE, i, 4'hf, 2'h0);
				rd(`OFF_REF_CHOICE, i, 2'h0);
				chk({29'h0, cfg.refChoice}, i, "reference output");
			end
		end
		for (i = 0; i < 8; i++) begin
			wr(`OFF_EXTREF_CHOICE, i, 4'hf, 2'h0);
			rd(`OFF_EXTREF_CHOICE, i, 2'h0);
			chk({29'h0, cfg.extRefChoice}, i, "external reference output");
		end
		for (i = 0; i < 3; i++) begin
			wr(`OFF_MODE, i | 32'h100, 4'hf, 2'h0);
			rd(`OFF_MODE, i | 32'h100, 2'h0);
			chk({29'h0, cfg.latencyPowerLevel, cfg.differential}, (i << 1) | 1, "mode outputs");
		end
		wr(`OFF_MODE, 32'h0000_0001, 4'h1, 2'h0);
		rd(`OFF_MODE, 32'h101, 2'h0);
		wr(`OFF_MODE, 32'h0, 4'h2, 2'h0);
		rd(`OFF_MODE, 32'h1, 2'h0);
		chk({31'h0, cfg.differential}, 32'h0, "single-ended output");
		wr(`OFF_BAND_ENABLE, 32'h1, 4'hf, 2'h0);
		rd(`OFF_BAND_ENABLE, 32'h1, 2'h0);
		chk({31'h0, cfg.hysteresis}, 32'h1, "hysteresis output");
		wr(`OFF_BAND_ENABLE, 32'h0, 4'hf, 2'h0);
		chk({31'h0, cfg.hysteresis}, 32'h0, "hysteresis output");
		wr(`OFF_ENABLE, 32'h2, 4'hf, 2'h0);
		rd(`OFF_ENABLE, 32'h2, 2'h0);
		chk({30'h0, cfg.enable}, 32'h2, "enable output");
		wr(`OFF_PIN_CHOICE, 32'h6, 4'hf, 2'h0);
		rd(`OFF_PIN_CHOICE, 32'h6, 2'h0);
		chk({29'h0, cfg.pinChoice}, 32'h6, "pin choice output");
		// Byte lanes 0 and 2 only on the second write
		wr(`OFF_EITHER_DIRECTION_EVENT_LEVELS, 32'h1234_5678, 4'hf, 2'h0);
		wr(`OFF_EITHER_DIRECTION_EVENT_LEVELS, 32'haaaa_aaaa, 4'h5, 2'h0);
		rd(`OFF_EITHER_DIRECTION_EVENT_LEVELS, 32'h12aa_56aa, 2'h0);
		chk(cfg.crossingLevels, 32'h12aa_56aa, "crossing levels output");
		$display("Test configuration fields done");

		// Both analog levels rise with every interrupt masked
		compOut <= 1'b1;
		compReady <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`OFF_RESULT, 32'h0, 2'h0);
		sampleTask <= 1'b1;
		@(posedge clk);
		sampleTask <= 1'b0;
		rd(`OFF_RESULT, 32'h1, 2'h0);
		wr(`OFF_RESULT, 32'h0, 4'hf, 2'h0);
		rd(`OFF_RESULT, 32'h1, 2'h0);
		compOut <= 1'b0;
		repeat (10) @(posedge clk);
		rd(`OFF_RESULT, 32'h1, 2'h0);
		sampleTask <= 1'b1;
		@(posedge clk);
		sampleTask <= 1'b0;
		rd(`OFF_RESULT, 32'h0, 2'h0);
		$display("Test compare result done");

		rd(`OFF_EVENT_STATUS, 32'hf, 2'h0);
		chk({31'h0, irq}, 32'h0, "interrupt while masked");
		wr(`OFF_EVENT_STATUS, 32'h6, 4'hf, 2'h0);
		rd(`OFF_EVENT_STATUS, 32'h9, 2'h0);
		wr(`OFF_IRQ_SET, 32'h2, 4'hf, 2'h0);
		wait_irq(1'b0);
		wr(`OFF_IRQ_SET, 32'h8, 4'hf, 2'h0);
		wait_irq(1'b1);
		wr(`OFF_IRQ_CLEAR, 32'h8, 4'hf, 2'h0);
		wait_irq(1'b0);
		wr(`OFF_IRQ_DIRECT, 32'h1, 4'hf, 2'h0);
		wait_irq(1'b1);
		wr(`OFF_EVENT_STATUS, 32'h1, 4'hf, 2'h0);
		wait_irq(1'b0);
		rd(`OFF_EVENT_STATUS, 32'h8, 2'h0);
		$display("Test interrupt path done");

		wr(12'hffc, 32'hffff_ffff, 4'hf, 2'h2);
		rd(12'hffc, 32'h0, 2'h2);
		rd(`OFF_REF_CHOICE, 32'h5, 2'h0);
		$display("Test unmapped access done");

		// Reset in mid-run with the interrupt raised and fields written
		wr(`OFF_IRQ_SET, 32'h8, 4'hf, 2'h0);
		wait_irq(1'b1);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "interrupt after reset");
		rd(`OFF_IRQ_DIRECT, 32'h0, 2'h0);
		rd(`OFF_REF_CHOICE, 32'h4, 2'h0);
		rd(`OFF_MODE, 32'h0, 2'h0);
		rd(`OFF_ENABLE, 32'h0, 2'h0);
		rd(`OFF_EITHER_DIRECTION_EVENT_LEVELS, 32'h0, 2'h0);
		$display("Test reset in mid-run done");
		wrap_up();
	end
endmodule
`default_nettype wire
